// file: ccpc_chk.sv
`include "ccpc_regs.vh"
module ccpc_chk (
  input logic clk, // Clock.
  input logic rst_b, // Reset, active low.
  input logic io_wr, // Write strobe.
  input logic sleep_fetch2, // Sleep opcode pulse.
  input logic io_stop, // Peripheral stop.
  input logic osc_run_q, // Oscillator enable.
  input logic core_clk_en_q, // Core clock enable.
  input logic clock_output_pin_en_q, // Clock pin enable.
  input logic clk_div1_q, // Divide select.
  input logic clock_doubler_q, // Doubler.
  input logic bus_grant_q, // Bus grant.
  input logic clock_out_low_drive_q, // Clock pad drive.
  input logic serial_pins_low_drive_q, // Serial drive.
  input logic control_pins_low_drive_q, // Control drive.
  input logic bus_pins_low_drive_q, // Bus drive.
  input logic [7:0] io_addr, // Address.
  input logic [7:0] io_wdata, // Write data.
  input logic [1:0] lp_mode_q // Armed mode.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] w1_q, w2_q;
  always_ff @(posedge clk) begin
    w1_q <= io_wdata;
    w2_q <= w1_q;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence opt_wr; io_wr && io_addr == `CCPC_ADDR_CPUOPT; endsequence
  sequence nap_go; sleep_fetch2 && io_stop; endsequence
  property mirror(s, o, int b); s |-> ##2 o == w2_q[b]; endproperty
  AST_DIV: assert property (mirror(opt_wr, clk_div1_q, 7))
    else $error("divide select wrong");
  AST_DBL: assert property (mirror(io_wr && io_addr == 8'h1e, clock_doubler_q, 7))
    else $error("doubler wrong");
  AST_LDCLK: assert property (mirror(opt_wr, clock_out_low_drive_q, 4))
    else $error("clock pad drive wrong");
  AST_LDSER: assert property (mirror(opt_wr, serial_pins_low_drive_q, 2))
    else $error("serial drive wrong");
  AST_LDCTL: assert property (mirror(opt_wr, control_pins_low_drive_q, 1))
    else $error("control drive wrong");
  AST_LDBUS: assert property (mirror(opt_wr, bus_pins_low_drive_q, 0))
    else $error("bus drive wrong");
  AST_IDLE: assert property (nap_go ##0 lp_mode_q == 2'h1 |=> osc_run_q && !core_clk_en_q
    && !clock_output_pin_en_q) else $error("idle entry wrong");
  AST_STBY: assert property (nap_go ##0 lp_mode_q[1] |=> !osc_run_q && !core_clk_en_q)
    else $error("standby entry wrong");
  AST_NOSLP: assert property (sleep_fetch2 && core_clk_en_q
    && (!io_stop || lp_mode_q == 2'h0) |=> core_clk_en_q) else $error("slept wrongly");
  AST_RST: assert property ($rose(rst_b) |-> !clk_div1_q && !clock_doubler_q && osc_run_q)
    else $error("reset state wrong");
  AST_GRANT: assert property (!osc_run_q |=> !bus_grant_q)
    else $error("grant during standby");
endmodule
bind ccpc_top ccpc_chk chk_i (.*);

// file: ccpc_core_mdl.sv
module ccpc_core_mdl (
  input logic clk, // Core clock.
  input logic slp, // One-cycle request for a sleep instruction.
  output logic sleep_fetch2 // Pulse as the second opcode is fetched.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Two stages stand for the two opcode fetches, so the pulse trails the request.
  logic op1_q = 1'b0;
  initial sleep_fetch2 = 1'b0;
  always @(posedge clk) begin
    op1_q <= slp;
    sleep_fetch2 <= op1_q;
  end
endmodule

// file: ccpc_regs.vh
`ifndef CCPC_REGS_VH
`define CCPC_REGS_VH
`define CCPC_ADDR_W 8
`define CCPC_ADDR_CLKMUL 8'h1e
`define CCPC_ADDR_CPUOPT 8'h1f
`define CCPC_BIT_DIV1 7
`define CCPC_BIT_LPHI 6
`define CCPC_BIT_BUSEN 5
`define CCPC_BIT_LDCLK 4
`define CCPC_BIT_LPLO 3
`define CCPC_BIT_LDSER 2
`define CCPC_BIT_LDCTL 1
`define CCPC_BIT_LDBUS 0
`define CCPC_BIT_DOUBLER 7
`define CCPC_CPUOPT_RST 8'h00
`define CCPC_CLKMUL_RST 1'b0
`define CCPC_CLKMUL_RSVD 7'h7f
`define CCPC_QUICK_CYC 64
`define CCPC_STAB_CYC 256
`define CCPC_CNT_W 9
`define CCPC_CNT_LAST 9'h001
`define CCPC_RDATA_NONE 8'h00
`endif

// file: ccpc_sync2.v
module ccpc_sync2 #(
  parameter W = 1
) (
  input wire clk, // Clock.
  input wire rst_b, // Synchronous reset, active low.
  input wire [W-1:0] d, // Asynchronous inputs.
  output reg [W-1:0] q // Synchronised outputs.
);
  reg [W-1:0] meta_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      // Ones are the idle level of the active-low pins served, so reset shows no request.
      meta_q <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: ccpc_top.v
// Behaviour
// - Option bit 7 selects divide-by-one, else two.
// - Reset clears divide select, starting divide-by-two.
// - Select hi 0, lo 1 enables idle.
// - Idle keeps oscillator, stops internal and output clocks.
// - Idle entry after second sleep opcode with stop.
// - Select hi 1, lo 0 enables standby, oscillator off.
// - Standby entry after second sleep opcode with stop.
// - Both selects give standby, 64-cycle clock restart.
// - Standby bus request granted after stabilisation timer.
// - Clock-output low-drive bit weakens clock pad.
// - Serial low-drive bit weakens serial pin group.
// - Control low-drive bit weakens bus control strobes.
// - Bus low-drive bit weakens address/data drivers.
// - Doubler bit doubles internal clock relative external.
// - Doubler disabled after power-up.
// - Doubler register reserved bits read as one.
`include "ccpc_regs.vh"
module ccpc_top #(
  parameter STAB_CYC = `CCPC_STAB_CYC,
  parameter QUICK_CYC = `CCPC_QUICK_CYC
) (
  input wire clk, // Oscillator-rate clock.
  input wire rst_b, // Synchronous reset, active low.
  input wire [`CCPC_ADDR_W-1:0] io_addr, // Internal I/O address.
  input wire io_wr, // Register write strobe, one cycle.
  input wire io_rd, // Register read strobe, one cycle.
  input wire [7:0] io_wdata, // Write data.
  output reg [7:0] io_rdata_q, // Read data, valid the cycle after io_rd.
  input wire sleep_fetch2, // Second sleep opcode fetched, one-cycle pulse.
  input wire io_stop, // Peripheral-stop bit from the core.
  input wire external_bus_request_n, // Bus request pin, active low.
  input wire irq_pending, // Enabled interrupt pending, from core logic.
  output reg osc_run_q, // Oscillator enable.
  output reg core_clk_en_q, // Clock enable for internal logic.
  output reg clock_output_pin_en_q, // Clock output pin enable.
  output reg clk_div1_q, // Internal clock is external divided by one.
  output reg clock_doubler_q, // Internal clock doubled.
  output reg bus_grant_q, // Bus request honoured.
  output reg [1:0] lp_mode_q, // Armed selects: 0 none, 1 idle, 2 standby, 3 quick standby.
  output reg clock_out_low_drive_q, // Clock pad at reduced strength.
  output reg serial_pins_low_drive_q, // Serial group at reduced strength.
  output reg control_pins_low_drive_q, // Control group at reduced strength.
  output reg bus_pins_low_drive_q // Address/data at reduced strength.
);
  localparam S_RUN = 4'b0001;
  localparam S_IDLE = 4'b0010;
  localparam S_STBY = 4'b0100;
  localparam S_WAKE = 4'b1000;

  reg [7:0] cpu_options_register_q;
  reg clock_doubler_ctl_q;
  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [`CCPC_CNT_W-1:0] cnt_q;
  reg [`CCPC_CNT_W-1:0] cnt_d;
  reg osc_run_d;
  reg core_clk_en_d;
  reg [7:0] rdata_d;
  wire external_bus_request_s_n;
  // Counts are cut to the counter width; the defaults fit in it.
  wire [`CCPC_CNT_W-1:0] stab_len = STAB_CYC[`CCPC_CNT_W-1:0];
  wire [`CCPC_CNT_W-1:0] quick_len = QUICK_CYC[`CCPC_CNT_W-1:0];

  // The request pin is not timed to this clock, so it passes two flops first.
  ccpc_sync2 #(.W(1)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(external_bus_request_n),
    .q(external_bus_request_s_n)
  );

  wire external_bus_request = ~external_bus_request_s_n;
  wire sel_hi = cpu_options_register_q[`CCPC_BIT_LPHI];
  wire sel_lo = cpu_options_register_q[`CCPC_BIT_LPLO];
  wire idle_en = ~sel_hi & sel_lo;
  wire stby_en = sel_hi;
  wire sleep_go = sleep_fetch2 & io_stop;
  // Bus request wakes standby only when the grant enable bit is set.
  wire stby_external_bus_request = external_bus_request & cpu_options_register_q[`CCPC_BIT_BUSEN];
  wire wake_ev = external_bus_request | irq_pending;
  wire sleep_idle = sleep_go & idle_en;
  wire sleep_stby = sleep_go & stby_en;
  wire stby_wake = irq_pending | stby_external_bus_request;
  wire [`CCPC_CNT_W-1:0] wake_len = sel_lo ? quick_len : stab_len;
  // The count is loaded on leaving standby; its last value marks a settled clock.
  wire wake_done = (st_q == S_WAKE) && (cnt_q <= `CCPC_CNT_LAST);
  // In run a request is honoured at once; out of standby only once the count is spent.
  wire bus_grant_d = external_bus_request & ((st_q == S_RUN) | (wake_done & stby_external_bus_request));

  // Only two addresses are decoded; any other reads as zero and takes no write.
  wire hit_opt = (io_addr == `CCPC_ADDR_CPUOPT);
  wire hit_mul = (io_addr == `CCPC_ADDR_CLKMUL);
  wire wr_opt = io_wr & hit_opt;
  wire wr_mul = io_wr & hit_mul;

  always @(posedge clk) begin
    if (!rst_b) begin
      cpu_options_register_q <= `CCPC_CPUOPT_RST;
      clock_doubler_ctl_q <= `CCPC_CLKMUL_RST;
    end else begin
      if (wr_opt) begin
        cpu_options_register_q <= io_wdata;
      end
      if (wr_mul) begin
        clock_doubler_ctl_q <= io_wdata[`CCPC_BIT_DOUBLER];
      end
    end
  end

  always @* begin
    rdata_d = `CCPC_RDATA_NONE;
    if (hit_opt) begin
      rdata_d = cpu_options_register_q;
    end else if (hit_mul) begin
      rdata_d = {clock_doubler_ctl_q, `CCPC_CLKMUL_RSVD};
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      io_rdata_q <= `CCPC_RDATA_NONE;
    end else if (io_rd) begin
      io_rdata_q <= rdata_d;
    end
  end

  // Standby leaves through the settle count; idle skips it, its oscillator never stopped.
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      S_RUN: begin
        if (sleep_idle) begin
          st_d = S_IDLE;
        end else if (sleep_stby) begin
          st_d = S_STBY;
        end
        // With both selects clear, sleep leaves the clocks alone.
      end
      S_IDLE: begin
        if (wake_ev) begin
          st_d = S_RUN;
        end
      end
      S_STBY: begin
        if (stby_wake) begin
          st_d = S_WAKE;
          cnt_d = wake_len;
        end
      end
      S_WAKE: begin
        if (wake_done) begin
          st_d = S_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d = S_RUN;
      end
    endcase
  end

  // Enables follow the next state, so they switch on the same edge as the state.
  always @* begin
    osc_run_d = 1'b1;
    core_clk_en_d = 1'b0;
    case (st_d)
      S_RUN: begin
        core_clk_en_d = 1'b1;
      end
      S_STBY: begin
        osc_run_d = 1'b0;
      end
      default: begin
        core_clk_en_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      st_q <= S_RUN;
      cnt_q <= {`CCPC_CNT_W{1'b0}};
      osc_run_q <= 1'b1;
      core_clk_en_q <= 1'b1;
      clock_output_pin_en_q <= 1'b1;
      bus_grant_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      osc_run_q <= osc_run_d;
      core_clk_en_q <= core_clk_en_d;
      clock_output_pin_en_q <= core_clk_en_d;
      bus_grant_q <= bus_grant_d;
    end
  end

  // Option copies are registered so that every select leaves a flip-flop.
  always @(posedge clk) begin
    if (!rst_b) begin
      clk_div1_q <= 1'b0;
      clock_doubler_q <= 1'b0;
      lp_mode_q <= 2'h0;
      clock_out_low_drive_q <= 1'b0;
      serial_pins_low_drive_q <= 1'b0;
      control_pins_low_drive_q <= 1'b0;
      bus_pins_low_drive_q <= 1'b0;
    end else begin
      clk_div1_q <= cpu_options_register_q[`CCPC_BIT_DIV1];
      clock_doubler_q <= clock_doubler_ctl_q;
      // The mode field shows the armed selects even while the core is running.
      lp_mode_q <= {sel_hi, sel_lo};
      clock_out_low_drive_q <= cpu_options_register_q[`CCPC_BIT_LDCLK];
      serial_pins_low_drive_q <= cpu_options_register_q[`CCPC_BIT_LDSER];
      control_pins_low_drive_q <= cpu_options_register_q[`CCPC_BIT_LDCTL];
      bus_pins_low_drive_q <= cpu_options_register_q[`CCPC_BIT_LDBUS];
    end
  end
endmodule

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, io_wr = 0, io_rd = 0, io_stop = 0, slp = 0, irq_pending = 0;
  logic external_bus_request_n = 1, sleep_fetch2, osc_run_q, core_clk_en_q, clk_div1_q;
  logic clock_output_pin_en_q, clock_doubler_q, bus_grant_q, clock_out_low_drive_q;
  logic serial_pins_low_drive_q, control_pins_low_drive_q, bus_pins_low_drive_q;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata_q;
  logic [1:0] lp_mode_q;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  ccpc_top #(.STAB_CYC(12), .QUICK_CYC(4)) uut (.*);
  ccpc_core_mdl core (.clk(clk), .slp(slp), .sleep_fetch2(sleep_fetch2));
  task automatic chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) {io_addr, io_wdata, io_wr} <= {a, d, 1'b1};
    @(posedge clk) io_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk) {io_addr, io_rd} <= {a, 1'b1};
    @(posedge clk) io_rd <= 1'b0;
    #1 chk(io_rdata_q, e);
  endtask
  task automatic pulse;
    @(posedge clk) slp <= 1'b1;
    @(posedge clk) slp <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic nap(input logic [7:0] m, input logic bus, input int lo);
    int n;
    n = 0;
    wr(8'h1f, m);
    chk(lp_mode_q, {m[6], m[3]});
    pulse;
    chk({osc_run_q, core_clk_en_q, clock_output_pin_en_q}, {!m[6], 2'b00});
    @(posedge clk) {irq_pending, external_bus_request_n} <= {!bus, !bus};
    while (core_clk_en_q !== 1'b1 && n < 100) begin
      @(negedge clk) n++;
      if (n == lo && bus) chk(bus_grant_q, 1'b0);
    end
    chk(n >= lo && n <= lo + 6, 1'b1);
    if (bus) chk(bus_grant_q, 1'b1);
    @(posedge clk) {irq_pending, external_bus_request_n} <= 2'b01;
    wr(8'h1f, 8'h00);
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 3000) begin
    $display("Error %0t: timeout", $time);
    n_errors++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk({clk_div1_q, clock_doubler_q, osc_run_q, core_clk_en_q, bus_grant_q}, 8'h06);
    rd(8'h1e, 8'h7f);
    rd(8'h20, 8'h00);
    rd(8'h1f, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h1f, i ? 8'h02 : 8'h95);
      chk({clk_div1_q, clock_out_low_drive_q, serial_pins_low_drive_q,
        control_pins_low_drive_q, bus_pins_low_drive_q}, i ? 8'h02 : 8'h1d);
      rd(8'h1f, i ? 8'h02 : 8'h95);
    end
    wr(8'h1e, 8'h80);
    chk(clock_doubler_q, 1'b1);
    rd(8'h1e, 8'hff);
    wr(8'h1e, 8'h00);
    $display("register test done");
    wr(8'h1f, 8'h08);
    pulse;
    chk(core_clk_en_q, 1'b1);
    @(posedge clk) io_stop <= 1'b1;
    wr(8'h1f, 8'h00);
    pulse;
    chk(core_clk_en_q, 1'b1);
    nap(8'h08, 1'b0, 0);
    nap(8'h40, 1'b0, 12);
    nap(8'h48, 1'b0, 4);
    nap(8'h60, 1'b1, 12);
    $display("power test done");
    test_done;
  end
endmodule
